/* include/sar_cfg.svh */
// Register map, field positions, reset values and step timing for the sequencer
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

// Register byte addresses on the register bus
`define MODE_ADDR 32'h0000_FF80
`define SEL_ADDR 32'h0000_FF84
`define RESULT_ADDR 32'h0000_FF88
`define FLAG_ADDR 32'h0000_FF8C

// Field positions
`define MODE_EN_BIT 7
`define TSEL_MSB 5
`define TSEL_LSB 3
`define CH_MSB 2
`define FLAG_BIT 4

// Reset values
`define MODE_RESET 8'h00
`define SEL_RESET 8'h00

// Conversion time codes (clocks per conversion)
`define TSEL_288 3'h0
`define TSEL_240 3'h1
`define TSEL_192 3'h2
`define TSEL_144 3'h4
`define TSEL_120 3'h5

// Sampling length and per-bit step length, in clocks; samp + 8 * step
`define SAMP_288 6'h20
`define STEP_288 6'h20
`define SAMP_240 6'h18
`define STEP_240 6'h1B
`define SAMP_192 6'h10
`define STEP_192 6'h16
`define SAMP_144 6'h10
`define STEP_144 6'h10
`define SAMP_120 6'h10
`define STEP_120 6'h0D

// Phase index of the last bit step
`define LAST_PHASE 4'h8

`endif

/* include/sar_pkg.sv */
// Types shared by the conversion sequencer files
package sar_pkg;

  // Register selected by a bus address
  typedef enum logic [1:0] {
    RI_MODE = 2'b00,
    RI_SEL = 2'b01,
    RI_RESULT = 2'b10,
    RI_FLAG = 2'b11
  } reg_idx_t;

  // Data phase of a bus transfer taken at the address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic hit;
    reg_idx_t idx;
  } dphase_t;

  // Mode register content
  typedef struct packed {
    logic enable;
    logic [2:0] tsel;
  } mode_t;

  // Drive to the sample-and-hold, input selector and tap selector
  typedef struct packed {
    logic [7:0] tap_code;
    logic [2:0] channel;
    logic sample_en;
  } analog_ctl_t;

endpackage

/* hdl/cmp_sync.sv */
// Two-flop synchroniser for the comparator output
`timescale 1ns/1ps
`default_nettype none
module cmp_sync (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Level in and out
  input wire logic d,
  output logic q
);
  logic meta;

  // First flop feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // cmp_sync
`default_nettype wire

/* hdl/conv_timer.sv */
// Phase timer: sampling phase then eight bit steps per conversion
`timescale 1ns/1ps
`default_nettype none
`include "sar_cfg.svh"
module conv_timer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic [2:0] tsel,
  // Status
  output logic [3:0] phase,
  output logic phase_end
);
  logic [5:0] cyc;
  logic [5:0] next_cyc;
  logic [3:0] next_phase;
  logic [5:0] len;

  // Length of a phase for a time code; prohibited codes run the slowest
  function automatic logic [5:0] phase_len(input logic [2:0] t,
                                           input logic samp);
    logic [5:0] r;
    unique case (t)
      `TSEL_240: r = samp ? `SAMP_240 : `STEP_240;
      `TSEL_192: r = samp ? `SAMP_192 : `STEP_192;
      `TSEL_144: r = samp ? `SAMP_144 : `STEP_144;
      `TSEL_120: r = samp ? `SAMP_120 : `STEP_120;
      default: r = samp ? `SAMP_288 : `STEP_288;
    endcase
    return r;
  endfunction

  assign len = phase_len(tsel, phase == 4'h0);
  assign phase_end = run && (cyc == len - 6'h01);

  // Count clocks within a phase and step through the phases
  always_comb begin
    next_cyc = cyc;
    next_phase = phase;
    if (clear) begin
      next_cyc = 6'h00;
      next_phase = 4'h0;
    end else if (phase_end) begin
      next_cyc = 6'h00;
      next_phase = (phase == `LAST_PHASE) ? 4'h0 : phase + 4'h1;
    end else if (run) begin
      next_cyc = cyc + 6'h01;
    end
  end

  // Timer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc <= 6'h00;
      phase <= 4'h0;
    end else begin
      cyc <= next_cyc;
      phase <= next_phase;
    end
  end
endmodule // conv_timer
`default_nettype wire

/* hdl/sar_conversion_sequencer.sv */
// Successive-approximation conversion sequencer with register slave
`timescale 1ns/1ps
`default_nettype none
`include "sar_cfg.svh"
module sar_conversion_sequencer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Power management
  input wire logic standby,
  // Analog side
  input wire logic cmp_in,
  output sar_pkg::analog_ctl_t analog_ctl,
  // Completion request
  output logic conv_done_irq
);

  // Register state
  sar_pkg::mode_t conv_mode_reg;
  sar_pkg::mode_t next_mode;
  logic [2:0] input_select_reg;
  logic [2:0] next_sel;
  logic [7:0] conv_result_reg;
  logic [7:0] next_result;
  logic conv_done_flag;
  logic next_flag;
  logic [7:0] approx_reg;
  logic [7:0] next_approx;
  logic next_irq;

  // Bus state
  sar_pkg::dphase_t dphase;
  sar_pkg::dphase_t next_dphase;
  logic [31:0] next_rdata;

  // Internal nets
  logic cmp_s;
  logic [3:0] phase;
  logic phase_end;
  logic run;
  logic reg_write;
  logic wr_mode;
  logic wr_sel;
  logic wr_flag;
  logic done;
  logic take;
  sar_pkg::reg_idx_t a_idx;
  logic a_hit;
  logic [2:0] a_dec;
  sar_pkg::analog_ctl_t next_analog;

  // Map a bus address to a register index and a hit flag
  // Full address compare; anything else reads zero and ignores writes
  function automatic logic [2:0] decode(input logic [31:0] a);
    logic [2:0] r;
    unique case (a)
      `MODE_ADDR: r = {1'b1, sar_pkg::RI_MODE};
      `SEL_ADDR: r = {1'b1, sar_pkg::RI_SEL};
      `RESULT_ADDR: r = {1'b1, sar_pkg::RI_RESULT};
      `FLAG_ADDR: r = {1'b1, sar_pkg::RI_FLAG};
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // Data-phase write strobe for one register
  function automatic logic wr_strobe(input sar_pkg::dphase_t dp,
                                     input sar_pkg::reg_idx_t idx);
    return dp.valid && dp.write && dp.hit && (dp.idx == idx);
  endfunction

  // Comparator output arrives from the analog domain
  cmp_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(cmp_in),
    .q(cmp_s)
  );

  // Step timing for the current time code
  // A mode or select register write clears it so the next run starts at sampling
  conv_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(reg_write),
    .run(run),
    .tsel(conv_mode_reg.tsel),
    .phase(phase),
    .phase_end(phase_end)
  );

  // Zero-wait slave, always OKAY
  // Every register answers in the data phase straight from flops
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase decode
  assign take = hsel && htrans[1] && hready;
  assign a_dec = decode(haddr);
  assign a_hit = a_dec[2];
  // Index bits always name one of the four registers
  assign a_idx = sar_pkg::reg_idx_t'(a_dec[1:0]);

  // Write strobes in the data phase
  assign wr_mode = wr_strobe(dphase, sar_pkg::RI_MODE);
  assign wr_sel = wr_strobe(dphase, sar_pkg::RI_SEL);
  assign wr_flag = wr_strobe(dphase, sar_pkg::RI_FLAG);
  assign reg_write = wr_mode || wr_sel;

  // A mode or select write cycle holds the timer, so no completion lands with it
  // standby freezes steps
  assign run = conv_mode_reg.enable && !standby && !reg_write;
  assign done = phase_end && phase == `LAST_PHASE;

  // Capture the transfer and the read value at the address phase
  always_comb begin
    next_dphase = '0;
    next_rdata = hrdata;
    if (take) begin
      next_dphase.valid = 1'b1;
      next_dphase.write = hwrite;
      next_dphase.hit = a_hit;
      next_dphase.idx = a_idx;
      next_rdata = 32'h0000_0000;
      // Back-to-back mode and select reads see a write landing at this edge
      if (!hwrite && a_hit) begin
        unique case (a_idx)
          sar_pkg::RI_MODE: begin
            next_rdata[`MODE_EN_BIT] = next_mode.enable;
            next_rdata[`TSEL_MSB:`TSEL_LSB] = next_mode.tsel;
          end
          sar_pkg::RI_SEL: next_rdata[`CH_MSB:0] = next_sel;
          sar_pkg::RI_RESULT: next_rdata[7:0] = conv_result_reg;
          sar_pkg::RI_FLAG: next_rdata[`FLAG_BIT] = conv_done_flag;
        endcase
      end
    end
  end

  // Bus registers
  // Read data holds until the next transfer is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase <= '0;
      hrdata <= 32'h0000_0000;
    end else begin
      dphase <= next_dphase;
      hrdata <= next_rdata;
    end
  end

  // Mode and select registers
  // Writes land at the end of their data phase
  always_comb begin
    next_mode = conv_mode_reg;
    next_sel = input_select_reg;
    if (wr_mode) begin
      next_mode.enable = hwdata[`MODE_EN_BIT];
      next_mode.tsel = hwdata[`TSEL_MSB:`TSEL_LSB];
    end
    if (wr_sel) begin
      next_sel = hwdata[`CH_MSB:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_mode_reg <= sar_pkg::mode_t'(4'h0);
      input_select_reg <= 3'h0;
    end else begin
      conv_mode_reg <= next_mode;
      input_select_reg <= next_sel;
    end
  end

  // Tap reaches the analog side one clock after the search register,
  // and the comparator comes back two clocks later; a step of thirteen
  // clocks or more leaves room for both before the bit is decided.
  // Binary search, result load, done request and flag
  always_comb begin
    logic [2:0] bitn;
    bitn = 3'(4'h8 - phase);
    next_approx = approx_reg;
    next_result = conv_result_reg;
    next_irq = 1'b0;
    next_flag = conv_done_flag;
    // Flag register write with the flag bit low clears it
    if (wr_flag && !hwdata[`FLAG_BIT]) begin
      next_flag = 1'b0;
    end
    if (reg_write) begin
      next_approx = 8'h00;
    end else if (run && phase_end) begin
      if (phase == 4'h0) begin
        next_approx = 8'h80;
      end else begin
        // input at or above tap is one
        next_approx[bitn] = cmp_s;
        if (bitn != 3'h0) begin
          next_approx[bitn - 3'h1] = 1'b1;
        end
      end
      if (done) begin
        next_result = {approx_reg[7:1], cmp_s};
        next_irq = 1'b1;
        // Set wins over a coinciding clear
        next_flag = 1'b1;
        next_approx = 8'h00;
      end
    end
  end

  // Search register, request pulse and flag; mode writes keep flag
  // The request is a one-clock pulse; the flag holds it for software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      approx_reg <= 8'h00;
      conv_done_irq <= 1'b0;
      conv_done_flag <= 1'b0;
    end else begin
      approx_reg <= next_approx;
      conv_done_irq <= next_irq;
      conv_done_flag <= next_flag;
    end
  end

  // result left uninitialised
  // No reset: the value means nothing until the first completion
  always_ff @(posedge hclk) begin
    conv_result_reg <= next_result;
  end

  // Analog drive; tap string is offset half a code
  always_comb begin
    next_analog.tap_code = approx_reg;
    next_analog.channel = input_select_reg;
    next_analog.sample_en = conv_mode_reg.enable && phase == 4'h0;
  end

  // Registered so the analog side never sees a decode glitch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_ctl <= '0;
    end else begin
      analog_ctl <= next_analog;
    end
  end

endmodule // sar_conversion_sequencer
`default_nettype wire

/* sim/sar_seq_monitor.sv */
// Port checker for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sar_cfg.svh"
module sar_seq_monitor (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Converter side
  input wire logic standby,
  input wire sar_pkg::analog_ctl_t analog_ctl,
  input wire logic conv_done_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic mode_wr;
  logic [10:0] gap;
  logic [10:0] next_gap;
  // Mode write address phase outside standby
  assign mode_wr = hsel && htrans[1] && hwrite && !standby
    && haddr == `MODE_ADDR;
  // Cycles since the last request, saturating
  always_comb begin
    next_gap = conv_done_irq ? 11'h000 : gap + {10'h000, gap != 11'h7FF};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap <= 11'h7FF;
    else gap <= next_gap;
  end
  AST_NO_WAIT: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or errored");
  AST_IRQ_PULSE: assert property (conv_done_irq |=> !conv_done_irq)
    else $error("done request longer than one cycle");
  AST_IRQ_GAP: assert property (conv_done_irq |-> gap >= 11'd119)
    else $error("conversion shorter than the shortest time");
  AST_SAMPLE_LEN: assert property ($rose(analog_ctl.sample_en) |->
    analog_ctl.sample_en [*8])
    else $error("sampling phase too short");
  AST_FIRST_TAP: assert property ($fell(analog_ctl.sample_en) |->
    ##[0:2] analog_ctl.tap_code == 8'h80)
    else $error("first step tap not midscale");
  AST_STANDBY_HOLD: assert property (standby && $past(standby) &&
    $past(standby, 2) |-> $stable(analog_ctl) && !conv_done_irq)
    else $error("sequencing moved in standby");
  AST_START: assert property (mode_wr ##1 hwdata[`MODE_EN_BIT] |->
    ##[1:2] analog_ctl.sample_en)
    else $error("enable write did not start sampling");
  AST_STOP: assert property (mode_wr ##1 !hwdata[`MODE_EN_BIT] |->
    ##2 (!analog_ctl.sample_en && !conv_done_irq) [*8])
    else $error("activity after disable write");
endmodule // sar_seq_monitor
bind sar_conversion_sequencer sar_seq_monitor u_mon (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
  .standby(standby), .analog_ctl(analog_ctl),
  .conv_done_irq(conv_done_irq));
`default_nettype wire

/* sim/analog_model.sv */
// Behavioural tap string, input selector and comparator
`timescale 1ns/1ps
`default_nettype none
module analog_model (
  // Drive from the sequencer
  input wire sar_pkg::analog_ctl_t analog_ctl,
  // Rounded code of each channel input
  input wire logic [63:0] vin,
  // Comparator out
  output logic cmp_in
);
  assign cmp_in = vin[analog_ctl.channel * 8 +: 8] >= analog_ctl.tap_code;
endmodule // analog_model
`default_nettype wire

/* sim/sar_conversion_sequencer_tb.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sar_cfg.svh"
module sar_conversion_sequencer_tb;
  logic hclk, hresetn, hsel, hwrite, standby, hreadyout, hresp;
  logic cmp_in, conv_done_irq, dp_rd;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [63:0] vin;
  logic [2:0] ch;
  sar_pkg::analog_ctl_t analog_ctl;
  logic [31:0] exp_q[$];
  int bad_count, n_tests, seed, n;
  localparam int ctime [5] = '{288, 240, 192, 144, 120};
  localparam logic [2:0] tcode [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};

  sar_conversion_sequencer DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .standby(standby), .cmp_in(cmp_in), .analog_ctl(analog_ctl),
    .conv_done_irq(conv_done_irq));
  analog_model PEER (.analog_ctl(analog_ctl), .vin(vin), .cmp_in(cmp_in));

  // Clock
  always #2 hclk = ~hclk;

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for ready at a rising edge
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
  endtask

  // One single transfer; for reads d is the expected word
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    if (!w) exp_q.push_back(d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0000_0000;
    wait_rdy();
  endtask

  // Edges until a done request is seen, bounded
  task automatic wait_irq(input int lim, input logic must, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (conv_done_irq !== 1'b1 && n < lim);
    if (must && conv_done_irq !== 1'b1) begin
      bad_count++;
      end_of_test();
    end
  endtask

  // Read data phase compared against the oldest expectation
  always @(posedge hclk) begin
    if (dp_rd) check(hrdata, exp_q.pop_front());
    dp_rd <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    standby = 1'b0;
    dp_rd = 1'b0;
    seed = 32194;
    vin = {$random(seed), $random(seed)};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `MODE_ADDR, 32'h0000_0000);
    bus(1'b0, `SEL_ADDR, 32'h0000_0000);
    bus(1'b0, 32'h0000_FF90, 32'h0000_0000);
    // Every time code on a random channel
    for (int i = 0; i < 5; i++) begin
      ch = 3'($random(seed));
      bus(1'b1, `SEL_ADDR, {29'h0, ch});
      bus(1'b1, `FLAG_ADDR, 32'h0000_0000);
      check({29'h0, analog_ctl.channel}, {29'h0, ch});
      bus(1'b1, `MODE_ADDR, {24'h0, 2'b10, tcode[i], 3'h0});
      wait_irq(400, 1'b1, n);
      check({31'h0, n >= ctime[i] && n <= ctime[i] + 3}, 32'h1);
      wait_irq(400, 1'b1, n);
      check(n, ctime[i]);
      bus(1'b0, `RESULT_ADDR, {24'h0, vin[ch * 8 +: 8]});
      bus(1'b0, `FLAG_ADDR, 32'h0000_0010);
    end
    bus(1'b1, `MODE_ADDR, 32'h0000_00A8);
    bus(1'b0, `FLAG_ADDR, 32'h0000_0010);
    // Select write in the completion cycle of the restarted conversion
    repeat (114) @(posedge hclk);
    bus(1'b1, `SEL_ADDR, {29'h0, ch});
    wait_irq(400, 1'b1, n);
    check(n, ctime[4] + 1);
    // Standby in mid conversion
    wait_irq(400, 1'b1, n);
    repeat (40) @(posedge hclk);
    standby <= 1'b1;
    wait_irq(600, 1'b0, n);
    check({31'h0, conv_done_irq}, 32'h0);
    standby <= 1'b0;
    wait_irq(200, 1'b1, n);
    // Stop after the result was read while running
    repeat (40) @(posedge hclk);
    bus(1'b0, `RESULT_ADDR, {24'h0, vin[ch * 8 +: 8]});
    bus(1'b1, `MODE_ADDR, 32'h0000_0028);
    wait_irq(600, 1'b0, n);
    check({31'h0, conv_done_irq}, 32'h0);
    // Standby entered only with conversion disabled
    standby <= 1'b1;
    repeat (20) @(posedge hclk);
    standby <= 1'b0;
    bus(1'b0, `MODE_ADDR, 32'h0000_0028);
    // Reset in mid conversion
    bus(1'b1, `MODE_ADDR, 32'h0000_00A8);
    repeat (50) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `MODE_ADDR, 32'h0000_0000);
    bus(1'b0, `SEL_ADDR, 32'h0000_0000);
    check({31'h0, analog_ctl.sample_en}, 32'h0);
    end_of_test();
  end
endmodule // sar_conversion_sequencer_tb
`default_nettype wire
